/* File: mfr_pkg.sv */
// Package with register map, field layout, sub-buffer layout, timing and state encoding of the buffer manager.
package mfr_pkg;

  // ****************************************************************
  // Register map (byte addresses on the APB bus)
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] BUF_BASE = 12'h100;
  localparam logic [11:0] BUF_MASK = 12'h0fc;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ****************************************************************
  // Register fields
  // ****************************************************************
  localparam int CTRL_MRX_EN_BIT = 0;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_IDLE_BIT = 1;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_RXFLAG_BIT = 8;
  localparam int STAT_ACTIVE_BIT = 9;
  localparam int STAT_WAITTX_BIT = 10;
  localparam int STAT_STATE_LSB = 16;

  // ****************************************************************
  // Sub-buffer layout and status word fields
  // ****************************************************************
  localparam int SUB_BYTES = 32;
  localparam int MAX_FRAMES = 8;
  localparam logic [7:0] MAX_PAYLOAD = 8'h1c;
  localparam logic [2:0] STATUS_WORD_IDX = 3'h7;
  localparam int SW_CNT_LSB = 0;
  localparam int SW_CERR_BIT = 8;
  localparam int SW_DERR_BIT = 9;
  localparam int SW_FERR_BIT = 10;
  localparam int SW_COLL_BIT = 11;
  localparam int SW_LERR_BIT = 12;

  // ****************************************************************
  // Timing: receiver off-time between frames
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 100000;
  localparam int RF_PERIOD_PS = 73746;
  localparam int GAP_RF_CYCLES = 2;
  localparam int GAP_CALC = (GAP_RF_CYCLES * RF_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYCLES = (GAP_CALC < 1) ? 1 : GAP_CALC;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LISTEN = 3'b001,
    ST_RECV = 3'b010,
    ST_STORE = 3'b011,
    ST_GAP = 3'b100,
    ST_WAIT_TX = 3'b101
  } mfr_state_e;

endpackage : mfr_pkg

/* File: mfr_multi_frame_rx_buffer.sv */
// Multiple-reception buffer manager: APB registers, frame sequencer, sub-buffer store and status words.
`timescale 1ns/1ps

module mfr_multi_frame_rx_buffer #(
  parameter int NUM_FRAMES = mfr_pkg::MAX_FRAMES,
  parameter int SUB_SIZE = mfr_pkg::SUB_BYTES
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Transceive state machine.
  input wire logic transceive_active_i,
  output logic wait_for_transmit_state_o,
  output logic multi_receive_cycle_o,
  // Decoder frame stream.
  input wire logic rx_sof_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_eof_i,
  input wire logic rx_crc_ok_i,
  input wire logic rx_collision_i,
  output logic rx_enable_o,
  output logic rx_frame_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The buffer window and addressing are sized for 32-byte sub-buffers and 1 to 8 frames.
  generate
    if (SUB_SIZE != mfr_pkg::SUB_BYTES || NUM_FRAMES < 1 || NUM_FRAMES > mfr_pkg::MAX_FRAMES) begin : g_bad_cfg
      $error("Unsupported sub-buffer size or frame count.");
    end
  endgenerate

  localparam logic [3:0] LAST_FRAME = 4'(NUM_FRAMES - 1);
  localparam logic [3:0] FRAME_LIMIT = 4'(NUM_FRAMES);
  localparam logic [3:0] GAP_LAST = 4'(mfr_pkg::GAP_CYCLES - 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  mfr_pkg::mfr_state_e state_reg;
  mfr_pkg::mfr_state_e state_next;
  logic mrx_en_reg;
  logic [3:0] frame_cnt_reg;
  logic [3:0] frame_cnt_next;
  logic rx_flag_reg;
  logic [7:0] len_reg;
  logic [7:0] byte_cnt_reg;
  logic len_over_reg;
  logic crc_bad_reg;
  logic coll_reg;
  logic [3:0] gap_cnt_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic [31:0] mem [64];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Decoded strobes and address hits; the slave always answers in the access cycle.
  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire hit_ctrl = (paddr_i == mfr_pkg::CTRL_OFS);
  wire hit_cmd = (paddr_i == mfr_pkg::CMD_OFS);
  wire hit_stat = (paddr_i == mfr_pkg::STAT_OFS);
  wire hit_buf = ((paddr_i & ~mfr_pkg::BUF_MASK) == mfr_pkg::BUF_BASE);
  wire hit_any = hit_ctrl | hit_cmd | hit_stat | hit_buf;
  wire [5:0] rd_word = paddr_i[7:2];
  wire cmd_start = apb_wr & hit_cmd & pwdata_i[mfr_pkg::CMD_START_BIT];
  wire cmd_idle = apb_wr & hit_cmd & pwdata_i[mfr_pkg::CMD_IDLE_BIT];
  wire flag_clr = apb_wr & hit_stat & pwdata_i[mfr_pkg::STAT_RXFLAG_BIT];

  // ****************************************************************
  // Sequencer conditions
  // ****************************************************************
  // The cycle may run only while enabled and the transceive machine is running.
  wire active = mrx_en_reg & transceive_active_i;
  wire start_go = cmd_start & active & ~cmd_idle;
  wire in_store = (state_reg == mfr_pkg::ST_STORE);
  wire in_recv = (state_reg == mfr_pkg::ST_RECV);

  // ****************************************************************
  // Payload write path
  // ****************************************************************
  // The first byte is the length byte; an oversized length blocks the whole payload.
  wire first_byte = (byte_cnt_reg == 8'h00);
  wire len_over_now = first_byte ? (rx_byte_i > mfr_pkg::MAX_PAYLOAD) : len_over_reg;
  wire pay_we = in_recv & rx_byte_valid_i & (byte_cnt_reg < mfr_pkg::MAX_PAYLOAD) & ~len_over_now;
  wire [5:0] sub_base = {frame_cnt_reg[2:0], 3'b000};
  wire [5:0] pay_word = sub_base + {3'b000, byte_cnt_reg[4:2]};
  wire [1:0] pay_lane = byte_cnt_reg[1:0];
  wire [5:0] stat_word = {frame_cnt_reg[2:0], mfr_pkg::STATUS_WORD_IDX};

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Error flags of the frame just closed; spare bits stay zero.
  wire data_err = crc_bad_reg;
  wire frame_err = (len_reg > byte_cnt_reg);
  wire len_err = len_over_reg | frame_err;
  wire comb_err = data_err | frame_err | coll_reg;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[mfr_pkg::SW_CNT_LSB +: 8] = byte_cnt_reg;
    status_word[mfr_pkg::SW_CERR_BIT] = comb_err;
    status_word[mfr_pkg::SW_DERR_BIT] = data_err;
    status_word[mfr_pkg::SW_FERR_BIT] = frame_err;
    status_word[mfr_pkg::SW_COLL_BIT] = coll_reg;
    status_word[mfr_pkg::SW_LERR_BIT] = len_err;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Idle command and loss of enable win over everything; a start re-opens the cycle.
  always_comb begin
    state_next = state_reg;
    if (cmd_idle || !active) begin
      state_next = mfr_pkg::ST_IDLE;
    end else if (start_go) begin
      state_next = mfr_pkg::ST_LISTEN;
    end else begin
      case (state_reg)
        mfr_pkg::ST_LISTEN: begin
          if (rx_sof_i) begin
            state_next = mfr_pkg::ST_RECV;
          end
        end
        mfr_pkg::ST_RECV: begin
          if (rx_eof_i) begin
            state_next = mfr_pkg::ST_STORE;
          end
        end
        mfr_pkg::ST_STORE: begin
          if (frame_cnt_reg >= LAST_FRAME) begin
            state_next = mfr_pkg::ST_WAIT_TX;
          end else begin
            state_next = mfr_pkg::ST_GAP;
          end
        end
        mfr_pkg::ST_GAP: begin
          if (gap_cnt_reg >= GAP_LAST) begin
            state_next = mfr_pkg::ST_LISTEN;
          end
        end
        mfr_pkg::ST_IDLE: begin
          state_next = mfr_pkg::ST_IDLE;
        end
        mfr_pkg::ST_WAIT_TX: begin
          state_next = mfr_pkg::ST_WAIT_TX;
        end
        default: begin
          state_next = mfr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Frame counter: cleared on start, bumped at each stored frame, held at the limit.
  always_comb begin
    frame_cnt_next = frame_cnt_reg;
    if (start_go) begin
      frame_cnt_next = 4'h0;
    end else if (in_store && frame_cnt_reg < FRAME_LIMIT) begin
      frame_cnt_next = frame_cnt_reg + 4'h1;
    end
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  // State, frame count and receive flag; a new frame beats a same-cycle clear.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= mfr_pkg::ST_IDLE;
      frame_cnt_reg <= 4'h0;
      rx_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      frame_cnt_reg <= frame_cnt_next;
      rx_flag_reg <= in_store | (rx_flag_reg & ~flag_clr);
    end
  end

  // Gap timer counts receiver off-time after each stored frame but the last.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt_reg <= 4'h0;
    end else if (state_reg == mfr_pkg::ST_GAP) begin
      gap_cnt_reg <= gap_cnt_reg + 4'h1;
    end else begin
      gap_cnt_reg <= 4'h0;
    end
  end

  // Per-frame capture of length byte, byte count and error inputs.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      len_reg <= 8'h00;
      byte_cnt_reg <= 8'h00;
      len_over_reg <= 1'b0;
      crc_bad_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else if (state_reg == mfr_pkg::ST_LISTEN && rx_sof_i) begin
      len_reg <= 8'h00;
      byte_cnt_reg <= 8'h00;
      len_over_reg <= 1'b0;
      crc_bad_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else if (in_recv) begin
      if (rx_byte_valid_i) begin
        if (first_byte) begin
          len_reg <= rx_byte_i;
          len_over_reg <= len_over_now;
        end
        if (byte_cnt_reg != 8'hff) begin
          byte_cnt_reg <= byte_cnt_reg + 8'h01;
        end
      end
      if (rx_eof_i) begin
        crc_bad_reg <= ~rx_crc_ok_i;
        coll_reg <= rx_collision_i;
      end
    end
  end

  // ****************************************************************
  // Receive buffer
  // ****************************************************************
  // Payload bytes go into their lane; the status word fills the last word of the sub-buffer.
  always_ff @(posedge mclk_i) begin
    if (pay_we) begin
      mem[pay_word][{pay_lane, 3'b000} +: 8] <= rx_byte_i;
    end
    if (in_store && frame_cnt_reg < FRAME_LIMIT) begin
      mem[stat_word] <= status_word;
    end
  end

  // ****************************************************************
  // APB registers
  // ****************************************************************
  // Control register write.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mrx_en_reg <= mfr_pkg::CTRL_RST[mfr_pkg::CTRL_MRX_EN_BIT];
    end else if (apb_wr && hit_ctrl) begin
      mrx_en_reg <= pwdata_i[mfr_pkg::CTRL_MRX_EN_BIT];
    end
  end

  // Read data selection; status shows count, flag, activity and state.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[mfr_pkg::CTRL_MRX_EN_BIT] = mrx_en_reg;
    end else if (hit_stat) begin
      rd_mux[mfr_pkg::STAT_CNT_LSB +: 4] = frame_cnt_reg;
      rd_mux[mfr_pkg::STAT_RXFLAG_BIT] = rx_flag_reg;
      rd_mux[mfr_pkg::STAT_ACTIVE_BIT] = multi_receive_cycle_o;
      rd_mux[mfr_pkg::STAT_WAITTX_BIT] = wait_for_transmit_state_o;
      rd_mux[mfr_pkg::STAT_STATE_LSB +: 3] = state_reg;
    end else if (hit_buf) begin
      rd_mux = mem[rd_word];
    end
  end

  // Read data and error are captured in the setup cycle and held through access.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
      slverr_reg <= ~hit_any;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Receiver enable, state indications and the per-frame strobe.
  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;
  assign pslverr_o = slverr_reg;
  assign rx_enable_o = (state_reg == mfr_pkg::ST_LISTEN) | in_recv;
  assign rx_frame_o = in_store;
  assign wait_for_transmit_state_o = (state_reg == mfr_pkg::ST_WAIT_TX);
  assign multi_receive_cycle_o = rx_enable_o | in_store | (state_reg == mfr_pkg::ST_GAP);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Receiver off-time between frames, count limits and status contents.
  a_gap_min_off: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(rx_enable_o) |-> (!rx_enable_o) [*2])
    else $error("Receiver re-armed too soon.");

  a_count_saturate: assert property (@(posedge mclk_i) disable iff (reset_i)
    frame_cnt_reg <= FRAME_LIMIT)
    else $error("Frame count beyond limit.");

  a_eighth_wait_tx: assert property (@(posedge mclk_i) disable iff (reset_i)
    (in_store && frame_cnt_reg == LAST_FRAME && active && !cmd_idle && !cmd_start)
    |=> wait_for_transmit_state_o && !rx_enable_o)
    else $error("No wait-for-transmit after last frame.");

  a_idle_stops: assert property (@(posedge mclk_i) disable iff (reset_i)
    cmd_idle |=> (state_reg == mfr_pkg::ST_IDLE) && !rx_enable_o)
    else $error("Idle command did not stop reception.");

  a_start_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    start_go |=> frame_cnt_reg == 4'h0 && rx_enable_o)
    else $error("Start did not clear frame count.");

  a_inactive_off: assert property (@(posedge mclk_i) disable iff (reset_i)
    !active |=> !rx_enable_o)
    else $error("Receiver enabled while feature inactive.");

  a_rearm_bound: assert property (@(posedge mclk_i) disable iff (reset_i)
    (in_store && frame_cnt_reg < LAST_FRAME) ##1 (active && !cmd_idle && !cmd_start) [*3]
    |=> rx_enable_o)
    else $error("Receiver not re-armed after frame.");

  a_flag_per_frame: assert property (@(posedge mclk_i) disable iff (reset_i)
    in_store |=> rx_flag_reg)
    else $error("Receive flag not set for frame.");

  a_count_update: assert property (@(posedge mclk_i) disable iff (reset_i)
    (in_store && !start_go && frame_cnt_reg < FRAME_LIMIT) |=> frame_cnt_reg == $past(frame_cnt_reg) + 4'h1)
    else $error("Frame count not updated.");

  a_payload_limit: assert property (@(posedge mclk_i) disable iff (reset_i)
    pay_we |-> byte_cnt_reg < mfr_pkg::MAX_PAYLOAD && pay_word[2:0] != mfr_pkg::STATUS_WORD_IDX
      && pay_word[5:3] == frame_cnt_reg[2:0])
    else $error("Payload byte beyond limit written.");

  a_oversize_no_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
    (in_recv && rx_byte_valid_i && first_byte && rx_byte_i > mfr_pkg::MAX_PAYLOAD) ##1 in_recv [*1]
    |-> !pay_we && len_over_reg)
    else $error("Payload copied despite oversized length.");

  a_status_fields: assert property (@(posedge mclk_i) disable iff (reset_i)
    in_store |-> status_word[31:13] == 19'h00000
      && status_word[mfr_pkg::SW_CERR_BIT] == (crc_bad_reg | coll_reg | (len_reg > byte_cnt_reg)))
    else $error("Status word fields inconsistent.");

  // Main scenarios.
  c_eighth_frame: cover property (@(posedge mclk_i) disable iff (reset_i)
    in_store && frame_cnt_reg == LAST_FRAME ##1 wait_for_transmit_state_o);
  c_length_error: cover property (@(posedge mclk_i) disable iff (reset_i)
    in_store && len_err);
  c_crc_error: cover property (@(posedge mclk_i) disable iff (reset_i)
    in_store && data_err && !frame_err);
  c_idle_in_frame: cover property (@(posedge mclk_i) disable iff (reset_i)
    in_recv && cmd_idle);

endmodule : mfr_multi_frame_rx_buffer

/* File: mfr_frame_src.sv */
// Frame source standing in for the demodulator and decoder.
`timescale 1ns/1ps
module mfr_frame_src (
  // Clock and receiver enable.
  input wire logic mclk_i,
  input wire logic rx_enable_i,
  // Decoded frame stream.
  output logic sof_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic eof_o,
  output logic crc_ok_o,
  output logic collision_o
);
  // Quiet stream at time zero.
  initial begin
    sof_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
    eof_o = 1'b0;
    crc_ok_o = 1'b0;
    collision_o = 1'b0;
  end

  // Sends one frame once the receiver is armed or after 64 cycles without it; the first byte is the length byte.
  task automatic send(input int len, input int n, input bit good, input bit coll, input logic [7:0] seed,
                      output bit ok);
    int w;
    w = 0;
    @(negedge mclk_i);
    while (rx_enable_i !== 1'b1 && w < 64) begin
      @(negedge mclk_i);
      w++;
    end
    ok = (rx_enable_i === 1'b1);
    @(posedge mclk_i);
    sof_o <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      sof_o <= 1'b0;
      byte_valid_o <= 1'b1;
      byte_o <= (i == 0) ? 8'(len) : seed + 8'(i);
    end
    // Released lines show the inverse of their last value, so stale data is never mistaken for valid.
    @(posedge mclk_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~byte_o;
    eof_o <= 1'b1;
    crc_ok_o <= good;
    collision_o <= coll;
    @(posedge mclk_i);
    eof_o <= 1'b0;
    crc_ok_o <= ~good;
    collision_o <= ~coll;
  endtask : send
endmodule : mfr_frame_src

/* File: mfr_multi_frame_rx_buffer_test.sv */
// Self-checking testbench of the multiple-reception buffer manager.
`timescale 1ns/1ps
module mfr_multi_frame_rx_buffer_test;
  // ****************
  // Signals and instances
  // ****************
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic active = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, wait_tx, cycle_on, rx_en, rx_frame, sof, bval, eof, crc, col;
  logic [7:0] rbyte;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int low_n = 0;
  int frames_seen = 0;
  int ln[8] = '{5, 6, 29, 10, 28, 4, 4, 4};
  int nb[8] = '{5, 6, 29, 4, 28, 4, 4, 4};
  bit ck[8] = '{1, 0, 1, 1, 1, 1, 1, 1};
  bit cl[8] = '{0, 0, 0, 0, 0, 1, 0, 0};

  // Clock of 100 ns period.
  always #50 mclk_i = ~mclk_i;

  mfr_multi_frame_rx_buffer i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .transceive_active_i(active), .wait_for_transmit_state_o(wait_tx),
    .multi_receive_cycle_o(cycle_on), .rx_sof_i(sof), .rx_byte_valid_i(bval), .rx_byte_i(rbyte),
    .rx_eof_i(eof), .rx_crc_ok_i(crc), .rx_collision_i(col), .rx_enable_o(rx_en), .rx_frame_o(rx_frame));

  mfr_frame_src i_src (.mclk_i(mclk_i), .rx_enable_i(rx_en), .sof_o(sof), .byte_valid_o(bval), .byte_o(rbyte),
    .eof_o(eof), .crc_ok_o(crc), .collision_o(col));

  // ****************
  // Tasks and monitors
  // ****************
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // One APB transfer: setup cycle, then access until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) begin
      @(posedge mclk_i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask : wr

  // Register read, masked and compared.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0, x, e);
    check(x & m, exp);
  endtask : rdchk

  // Byte j of frame k as the source sends it.
  function automatic logic [7:0] bv(input int k, input int j);
    return (j == 0) ? 8'(ln[k]) : 8'(16 * k + j);
  endfunction : bv

  // Expected status word of a frame.
  function automatic logic [31:0] sw(input int len, input int n, input logic c_ok, input logic c);
    logic le, fe;
    le = (len > 28) || (len > n);
    fe = len > n;
    return {19'h0, le, c, fe, ~c_ok, ~c_ok | fe | c, 8'(n)};
  endfunction : sw

  // Counts stored frames and measures each receiver off-time inside a cycle.
  always @(negedge mclk_i) begin
    if (rx_frame === 1'b1) frames_seen++;
    if (cycle_on === 1'b1 && rx_en === 1'b0) low_n++;
    else begin
      if (low_n != 0 && rx_en === 1'b1) check(low_n, mfr_pkg::GAP_CYCLES + 1);
      low_n = 0;
    end
  end

  // Cuts a hang short.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  // ****************
  // Tests
  // ****************
  // Main sequence.
  initial begin
    logic [31:0] x;
    logic e;
    bit ok;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdchk(mfr_pkg::CTRL_OFS, '1, mfr_pkg::CTRL_RST);
    rdchk(mfr_pkg::STAT_OFS, 32'h0000_070f, 32'h0);
    apb(1'b1, 12'h010, 32'h1, x, e);
    check(e, 1'b1);
    $display("test registers done");
    wr(mfr_pkg::CMD_OFS, 32'h1);
    repeat (2) @(negedge mclk_i);
    check(cycle_on, 1'b0);
    wr(mfr_pkg::CTRL_OFS, 32'h1);
    wr(mfr_pkg::CMD_OFS, 32'h1);
    repeat (2) @(negedge mclk_i);
    check(cycle_on, 1'b0);
    @(posedge mclk_i);
    active <= 1'b1;
    wr(mfr_pkg::CMD_OFS, 32'h1);
    repeat (2) @(negedge mclk_i);
    check(cycle_on, 1'b1);
    $display("test enable done");
    for (int k = 0; k < 8; k++) begin
      i_src.send(ln[k], nb[k], ck[k], cl[k], 8'(16 * k), ok);
      check(ok, 1'b1);
      rdchk(mfr_pkg::STAT_OFS, 32'hf, 32'(k + 1));
      if (k == 0) begin
        rdchk(mfr_pkg::STAT_OFS, 32'h100, 32'h100);
        wr(mfr_pkg::STAT_OFS, 32'h100);
        rdchk(mfr_pkg::STAT_OFS, 32'h100, 32'h0);
      end
    end
    repeat (4) @(negedge mclk_i);
    check(wait_tx, 1'b1);
    check(rx_en, 1'b0);
    check(frames_seen, 8);
    rdchk(mfr_pkg::STAT_OFS, 32'hf, 32'h8);
    $display("test frames done");
    // Status words and leading payload words; of the bytes in between, only bytes 24 to 27 of frame 4 are read.
    for (int k = 0; k < 8; k++) begin
      rdchk(mfr_pkg::BUF_BASE + 12'(32 * k + 28), '1, sw(ln[k], nb[k], ck[k], cl[k]));
      if (k != 2) rdchk(mfr_pkg::BUF_BASE + 12'(32 * k), '1, {bv(k, 3), bv(k, 2), bv(k, 1), bv(k, 0)});
    end
    rdchk(mfr_pkg::BUF_BASE + 12'h098, '1, {bv(4, 27), bv(4, 26), bv(4, 25), bv(4, 24)});
    $display("test buffer done");
    wr(mfr_pkg::CMD_OFS, 32'h1);
    rdchk(mfr_pkg::STAT_OFS, 32'hf, 32'h0);
    i_src.send(4, 4, 1'b1, 1'b0, 8'h70, ok);
    check(ok, 1'b1);
    rdchk(mfr_pkg::STAT_OFS, 32'hf, 32'h1);
    wr(mfr_pkg::CMD_OFS, 32'h2);
    repeat (2) @(negedge mclk_i);
    check(cycle_on, 1'b0);
    check(rx_en, 1'b0);
    wr(mfr_pkg::CMD_OFS, 32'h1);
    repeat (2) @(negedge mclk_i);
    check(rx_en, 1'b1);
    @(posedge mclk_i);
    active <= 1'b0;
    repeat (2) @(negedge mclk_i);
    check(cycle_on, 1'b0);
    check(rx_en, 1'b0);
    $display("test idle done");
    conclude();
  end
endmodule : mfr_multi_frame_rx_buffer_test
